// >>> verilog/csp_counter.sv
`timescale 1ns/100ps
`default_nettype none

module csp_fifo
    import csp_pkg::*;
#(
    parameter int W = CSP_CNT_W,
    parameter int D = CSP_FIFO_DEPTH
) (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    localparam int AW = $clog2(D);
    logic [W-1:0] mem [D];
    logic [AW-1:0] wr_r;
    logic [AW-1:0] rd_r;
    logic [AW:0] fill_r;
    logic do_wr;
    logic do_rd;

    assign in_ready = (fill_r != (AW+1)'(D));
    assign out_valid = (fill_r != '0);
    assign out_data = mem[rd_r];
    assign do_wr = in_valid & in_ready;
    assign do_rd = out_valid & out_ready;

    always_ff @(posedge core_clk) begin
        if (do_wr) begin
            mem[wr_r] <= in_data;
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            wr_r <= '0;
            rd_r <= '0;
            fill_r <= '0;
        end else begin
            if (do_wr) begin
                wr_r <= wr_r + AW'(1);
            end
            if (do_rd) begin
                rd_r <= rd_r + AW'(1);
            end
            fill_r <= fill_r + (AW+1)'(do_wr) - (AW+1)'(do_rd);
        end
    end
endmodule : csp_fifo

module csp_counter
    import csp_pkg::*;
(
    input wire logic core_clk,
    input wire logic arst_n,
    input wire csp_cfg_t cfg,
    input wire logic arm,
    input wire logic disarm,
    input wire logic pg_start,
    input wire logic [CSP_CNT_W-1:0] pg_width,
    input wire logic ext_source,
    input wire logic programmable_function_terminal,
    input wire logic interboard_trigger_bus,
    output logic out_valid,
    input wire logic out_ready,
    output logic [CSP_CNT_W-1:0] out_count,
    output logic [CSP_CNT_W-1:0] save_value,
    output logic save_done,
    output logic pulse_out,
    output logic capture_lost,
    output logic busy
);
    function automatic logic csp_rise(input logic [2:0] s);
        return s[1] & ~s[2];
    endfunction

    function automatic logic csp_fall(input logic [2:0] s);
        return ~s[1] & s[2];
    endfunction

    csp_state_s_t r;
    csp_state_s_t n;
    logic fifo_ready;
    logic ext_edge;
    logic src_edge;
    logic gate_lvl;
    logic gate_act;
    logic prev_act;
    logic act_edge;
    logic any_edge;
    logic buffered;
    logic cap;

    // ------------------------------------------------------------
    // Source and gate selection
    // ------------------------------------------------------------
    assign ext_edge = cfg.src_fall ? csp_fall(r.src_s) : csp_rise(r.src_s);
    always_comb begin
        case (cfg.src_sel)
            CSP_SRC_FAST: src_edge = 1'b1;
            CSP_SRC_SLOW: src_edge = r.slow_tick;
            default: src_edge = ext_edge;
        endcase
        case (cfg.gate_sel)
            CSP_GATE_PFT: gate_lvl = r.pft_s[1];
            CSP_GATE_ITB: gate_lvl = r.itb_s[1];
            default: gate_lvl = r.pg_on;
        endcase
    end
    assign gate_act = cfg.gate_high ? gate_lvl : ~gate_lvl;
    assign prev_act = cfg.gate_high ? r.gate_prev : ~r.gate_prev;
    assign act_edge = gate_act & ~prev_act;
    assign any_edge = gate_lvl ^ r.gate_prev;
    assign buffered = cfg.mode[1];
    assign cap = (cfg.mode == CSP_MODE_BUF_SEMI) ? any_edge : act_edge;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        n = r;
        n.src_s = {r.src_s[1:0], ext_source};
        n.pft_s = {r.pft_s[1:0], programmable_function_terminal};
        n.itb_s = {r.itb_s[1:0], interboard_trigger_bus};
        n.gate_prev = gate_lvl;
        n.push = 1'b0;
        n.slow_tick = 1'b0;
        if (r.div == CSP_SLOW_DIV_LAST) begin
            n.div = 16'h0;
            n.slow_tick = 1'b1;
        end else begin
            n.div = r.div + 16'h1;
        end
        if (r.push && !fifo_ready) begin
            n.lost = 1'b1;
        end
        // Pulse generator: width counted in external Source edges
        if (!r.pg_on) begin
            if (pg_start && pg_width != CSP_CNT_ZERO) begin
                n.pg_on = 1'b1;
                n.pg_cnt = CSP_CNT_ZERO;
            end
        end else if (ext_edge) begin
            n.pg_cnt = r.pg_cnt + CSP_CNT_ONE;
            if (r.pg_cnt + CSP_CNT_ONE == pg_width) begin
                n.pg_on = 1'b0;
            end
        end
        case (r.st)
            CSP_WAIT: begin
                if (act_edge) begin
                    n.st = CSP_COUNT;
                    n.cnt = src_edge ? CSP_CNT_ONE : CSP_CNT_ZERO;
                end
            end
            CSP_COUNT: begin
                if (!buffered) begin
                    if (!gate_act) begin
                        n.save = r.cnt;
                        n.save_done = 1'b1;
                        n.st = CSP_DONE;
                    end else if (src_edge) begin
                        n.cnt = r.cnt + CSP_CNT_ONE;
                    end
                end else if (cap) begin
                    n.save = r.cnt;
                    n.push = 1'b1;
                    n.push_data = r.cnt;
                    n.cnt = src_edge ? CSP_CNT_ONE : CSP_CNT_ZERO;
                end else if (src_edge) begin
                    n.cnt = r.cnt + CSP_CNT_ONE;
                end
            end
            default: begin
            end
        endcase
        if (disarm) begin
            n.st = CSP_IDLE;
        end else if (arm) begin
            n.st = buffered ? CSP_COUNT : CSP_WAIT;
            n.cnt = CSP_CNT_ZERO;
            n.save_done = 1'b0;
            n.lost = r.push && !fifo_ready;
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            r <= '{st: CSP_IDLE, default: '0};
        end else begin
            r <= n;
        end
    end

    csp_fifo #(.W(CSP_CNT_W), .D(CSP_FIFO_DEPTH)) u_fifo (
        .core_clk(core_clk),
        .arst_n(arst_n),
        .in_valid(r.push),
        .in_ready(fifo_ready),
        .in_data(r.push_data),
        .out_valid(out_valid),
        .out_ready(out_ready),
        .out_data(out_count)
    );

    assign save_value = r.save;
    assign save_done = r.save_done;
    assign pulse_out = r.pg_on;
    assign capture_lost = r.lost;
    assign busy = (r.st == CSP_WAIT) || (r.st == CSP_COUNT);

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    property p_done_holds;
        @(posedge core_clk) disable iff (!arst_n)
        (r.st == CSP_DONE && !arm && !disarm) |=> (r.st == CSP_DONE) && $stable(r.save);
    endproperty
    a_done_holds: assert property (p_done_holds) else $error("single result changed after stop");

    property p_single_latch;
        @(posedge core_clk) disable iff (!arst_n)
        (r.st == CSP_COUNT && !buffered && !gate_act && !arm && !disarm)
        |=> save_done && (save_value == $past(r.cnt));
    endproperty
    a_single_latch: assert property (p_single_latch) else $error("single latch wrong");

    property p_buf_capture;
        @(posedge core_clk) disable iff (!arst_n)
        (r.st == CSP_COUNT && buffered && cap && !arm && !disarm)
        |=> r.push && (r.push_data == $past(r.cnt));
    endproperty
    a_buf_capture: assert property (p_buf_capture) else $error("buffered capture missed");

    property p_restart;
        @(posedge core_clk) disable iff (!arst_n)
        (r.st == CSP_COUNT && buffered && cap && !arm && !disarm)
        |=> r.cnt == ($past(src_edge) ? CSP_CNT_ONE : CSP_CNT_ZERO);
    endproperty
    a_restart: assert property (p_restart) else $error("count not restarted");

    property p_arm_start;
        @(posedge core_clk) disable iff (!arst_n)
        (arm && !disarm && buffered) |=> (r.st == CSP_COUNT) && (r.cnt == '0);
    endproperty
    a_arm_start: assert property (p_arm_start) else $error("arm did not start count");

    property p_lost;
        @(posedge core_clk) disable iff (!arst_n)
        (r.push && !fifo_ready) |=> capture_lost;
    endproperty
    a_lost: assert property (p_lost) else $error("dropped capture not flagged");

    property p_pulse_end;
        @(posedge core_clk) disable iff (!arst_n)
        (r.pg_on && ext_edge && (r.pg_cnt + CSP_CNT_ONE == pg_width)) |=> !pulse_out;
    endproperty
    a_pulse_end: assert property (p_pulse_end) else $error("pulse width wrong");

    property p_slow_tick;
        @(posedge core_clk) disable iff (!arst_n)
        $rose(r.slow_tick) |=> !r.slow_tick [*8];
    endproperty
    a_slow_tick: assert property (p_slow_tick) else $error("slow timebase too fast");

    property p_one_inc;
        @(posedge core_clk) disable iff (!arst_n)
        (r.st == CSP_COUNT && !cap && gate_act && !arm && !disarm)
        |=> (r.cnt - $past(r.cnt)) <= CSP_CNT_ONE;
    endproperty
    a_one_inc: assert property (p_one_inc) else $error("more than one increment");
endmodule : csp_counter
`default_nettype wire

// >>> pkg/csp_pkg.sv
`default_nettype none
package csp_pkg;
    localparam int CSP_CNT_W = 32;
    localparam int CSP_FIFO_DEPTH = 16;
    localparam int CSP_CLK_PERIOD_NS = 25;
    // Slow timebase period: 10 us gives 100 kHz, for gates slower than 0.01 Hz
    localparam int CSP_SLOW_TB_PERIOD_NS = 10000;
    localparam int CSP_SLOW_TB_CYCLES = CSP_SLOW_TB_PERIOD_NS / CSP_CLK_PERIOD_NS;
    localparam logic [15:0] CSP_SLOW_DIV_LAST = 16'(CSP_SLOW_TB_CYCLES - 1);
    localparam logic [CSP_CNT_W-1:0] CSP_CNT_ZERO = 32'h0;
    localparam logic [CSP_CNT_W-1:0] CSP_CNT_ONE = 32'h1;

    typedef enum logic [3:0] {
        CSP_IDLE = 4'h1,
        CSP_WAIT = 4'h2,
        CSP_COUNT = 4'h4,
        CSP_DONE = 4'h8
    } csp_state_t;

    typedef enum logic [1:0] {
        CSP_MODE_SINGLE_SEMI = 2'h0,
        CSP_MODE_SINGLE_PW = 2'h1,
        CSP_MODE_BUF_SEMI = 2'h2,
        CSP_MODE_BUF_PERIOD = 2'h3
    } csp_mode_t;

    typedef enum logic [1:0] {
        CSP_SRC_FAST = 2'h0,
        CSP_SRC_SLOW = 2'h1,
        CSP_SRC_EXT = 2'h2
    } csp_src_t;

    typedef enum logic [1:0] {
        CSP_GATE_PFT = 2'h0,
        CSP_GATE_ITB = 2'h1,
        CSP_GATE_PULSE = 2'h2
    } csp_gate_t;

    typedef struct packed {
        csp_mode_t mode;
        logic gate_high;
        logic src_fall;
        csp_src_t src_sel;
        csp_gate_t gate_sel;
    } csp_cfg_t;

    typedef struct packed {
        logic [2:0] src_s;
        logic [2:0] pft_s;
        logic [2:0] itb_s;
        csp_state_t st;
        logic gate_prev;
        logic [CSP_CNT_W-1:0] cnt;
        logic [CSP_CNT_W-1:0] save;
        logic save_done;
        logic push;
        logic [CSP_CNT_W-1:0] push_data;
        logic lost;
        logic [15:0] div;
        logic slow_tick;
        logic pg_on;
        logic [CSP_CNT_W-1:0] pg_cnt;
    } csp_state_s_t;
endpackage : csp_pkg
`default_nettype wire

// >>> tb/csp_far_side.sv
`timescale 1ns/100ps
`default_nettype none
module csp_far_side
    import csp_pkg::*;
(
    input wire logic core_clk,
    input wire logic gate_en,
    input wire logic [15:0] gate_half,
    input wire logic use_itb,
    input wire logic src_en,
    input wire logic stall,
    input wire logic out_valid,
    input wire logic [CSP_CNT_W-1:0] out_count,
    output logic gate_pft,
    output logic gate_itb,
    output logic ext_source,
    output logic out_ready
);
    logic [CSP_CNT_W-1:0] words[$];
    int gc = 0;
    int sc = 0;
    logic gate = 1'b0;
    logic noise = 1'b0;
    initial begin
        gate_pft = 1'b0;
        gate_itb = 1'b0;
        ext_source = 1'b0;
        out_ready = 1'b1;
    end
    // Unselected gate line toggles every cycle so a wrong gate choice shows
    always @(negedge core_clk) begin
        gc = gate_en ? gc + 1 : 0;
        if (gc == int'(gate_half)) begin
            gc = 0;
            gate = ~gate;
        end
        sc = src_en ? sc + 1 : 0;
        if (sc == 3) begin
            sc = 0;
            ext_source = ~ext_source;
        end
        gate_pft = use_itb ? noise : gate;
        gate_itb = use_itb ? gate : noise;
        noise = ~noise;
        out_ready = ~stall;
    end
    // DMA sink keeps words in arrival order
    always @(posedge core_clk) begin
        if (out_valid === 1'b1 && out_ready) begin
            words.push_back(out_count);
        end
    end
endmodule : csp_far_side
`default_nettype wire

// >>> tb/testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench
    import csp_pkg::*;
;
    logic core_clk = 1'b0;
    logic arst_n = 1'b0;
    csp_cfg_t cfg = '0;
    logic arm = 1'b0;
    logic disarm = 1'b0;
    logic pg_start = 1'b0;
    logic [CSP_CNT_W-1:0] pg_width = '0;
    logic ext_source, pft, itb, out_valid, out_ready, save_done, pulse_out;
    logic capture_lost, busy;
    logic [CSP_CNT_W-1:0] out_count, save_value, v;
    logic gate_en = 1'b0;
    logic [15:0] gate_half = 16'h0014;
    logic use_itb = 1'b0;
    logic src_en = 1'b0;
    logic stall = 1'b0;
    logic gate_low = 1'b0;
    logic src_fall = 1'b0;
    int num_errors = 0;
    int checks = 0;

    csp_counter DUT (.core_clk(core_clk), .arst_n(arst_n), .cfg(cfg), .arm(arm),
        .disarm(disarm), .pg_start(pg_start), .pg_width(pg_width), .ext_source(ext_source),
        .programmable_function_terminal(pft), .interboard_trigger_bus(itb),
        .out_valid(out_valid), .out_ready(out_ready), .out_count(out_count),
        .save_value(save_value), .save_done(save_done), .pulse_out(pulse_out),
        .capture_lost(capture_lost), .busy(busy));
    csp_far_side far (.core_clk(core_clk), .gate_en(gate_en), .gate_half(gate_half),
        .use_itb(use_itb), .src_en(src_en), .stall(stall), .out_valid(out_valid),
        .out_count(out_count), .gate_pft(pft), .gate_itb(itb), .ext_source(ext_source),
        .out_ready(out_ready));

    initial begin
        forever #12.5 core_clk = ~core_clk;
    end

    task give_verdict;
        $display("checks %0d mismatches %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : give_verdict

    task check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    // Count may be one off depending on gate phase
    function automatic logic [31:0] near(input logic [31:0] x, input int e);
        return (int'(x) + 1 >= e && int'(x) <= e + 1) ? 32'h1 : 32'h0;
    endfunction : near

    task cyc(input int n);
        repeat (n) @(negedge core_clk);
    endtask : cyc

    task start(input csp_mode_t m, input csp_src_t s, input csp_gate_t g, input int h);
        cfg = '{m, ~gate_low, src_fall, s, g};
        gate_half = 16'(h);
        use_itb = (g == CSP_GATE_ITB);
        gate_en = (g != CSP_GATE_PULSE);
        cyc(h / 2);
        arm = 1'b1;
        cyc(1);
        arm = 1'b0;
    endtask : start

    task stop;
        disarm = 1'b1;
        gate_en = 1'b0;
        src_en = 1'b0;
        cyc(1);
        disarm = 1'b0;
        cyc(8);
        far.words.delete();
    endtask : stop

    task wait_for(input int n, input logic single);
        int i;
        for (i = 0; i < 20000 && (single ? save_done !== 1'b1 : far.words.size() < n); i++) begin
            cyc(1);
        end
        if (i == 20000) begin
            check(32'(far.words.size()), 32'(n));
            give_verdict();
        end
    endtask : wait_for

    task test_stream(input csp_mode_t m, input csp_gate_t g, input int e);
        int i;
        start(m, CSP_SRC_FAST, g, 20);
        wait_for(5, 1'b0);
        check(32'(busy), 32'h1);
        check(32'(int'(far.words[0]) < e - 2), 32'h1);
        for (i = 1; i < 5; i++) begin
            check(near(far.words[i], e), 32'h1);
        end
        stop();
        $display("stream test mode %0d done", m);
    endtask : test_stream

    task test_single(input csp_mode_t m, input csp_src_t s, input int h, input int e);
        start(m, s, CSP_GATE_PFT, h);
        check(32'(busy), 32'h1);
        wait_for(1, 1'b1);
        check(near(save_value, e), 32'h1);
        v = save_value;
        cyc(3 * h);
        check(save_value, v);
        check(32'(save_done), 32'h1);
        check(32'(busy), 32'h0);
        stop();
        $display("single test mode %0d source %0d done", m, s);
    endtask : test_single

    task test_pulse;
        pg_width = 32'h5;
        src_en = 1'b1;
        start(CSP_MODE_SINGLE_PW, CSP_SRC_EXT, CSP_GATE_PULSE, 8);
        pg_start = 1'b1;
        cyc(1);
        pg_start = 1'b0;
        check(32'(pulse_out), 32'h1);
        wait_for(1, 1'b1);
        check(near(save_value, 5), 32'h1);
        check(32'(pulse_out), 32'h0);
        stop();
        $display("pulse test done");
    endtask : test_pulse

    task test_fifo;
        stall = 1'b1;
        start(CSP_MODE_BUF_SEMI, CSP_SRC_FAST, CSP_GATE_PFT, 8);
        cyc(8 * 24);
        check(32'(capture_lost), 32'h1);
        check(32'(out_valid), 32'h1);
        gate_en = 1'b0;
        disarm = 1'b1;
        cyc(1);
        disarm = 1'b0;
        stall = 1'b0;
        cyc(40);
        check(32'(far.words.size()), 32'(CSP_FIFO_DEPTH));
        check(near(far.words[1], 8), 32'h1);
        check(32'(out_valid), 32'h0);
        arm = 1'b1;
        cyc(1);
        arm = 1'b0;
        cyc(2);
        check(32'(capture_lost), 32'h0);
        stop();
        $display("fifo test done");
    endtask : test_fifo

    initial begin
        cyc(5);
        arst_n = 1'b1;
        cyc(1);
        test_stream(CSP_MODE_BUF_SEMI, CSP_GATE_PFT, 20);
        test_stream(CSP_MODE_BUF_PERIOD, CSP_GATE_ITB, 40);
        test_single(CSP_MODE_SINGLE_SEMI, CSP_SRC_FAST, 30, 30);
        test_single(CSP_MODE_SINGLE_PW, CSP_SRC_FAST, 30, 30);
        test_single(CSP_MODE_SINGLE_PW, CSP_SRC_SLOW, 4000, 4000 / CSP_SLOW_TB_CYCLES);
        gate_low = 1'b1;
        test_single(CSP_MODE_SINGLE_SEMI, CSP_SRC_FAST, 30, 30);
        gate_low = 1'b0;
        test_pulse();
        src_fall = 1'b1;
        test_pulse();
        src_fall = 1'b0;
        test_fifo();
        give_verdict();
    end
endmodule : testbench
`default_nettype wire
